//--- inc/wakeup_opt_consts.vh
`ifndef WAKEUP_OPT_CONSTS_VH
`define WAKEUP_OPT_CONSTS_VH

// Register indices; byte address is four times the index.
`define IDX_PORT_A 8'h00
`define IDX_KEY_WAKE_SC 8'h1A
`define IDX_KEY_WAKE_IE 8'h1B
`define IDX_OPTION_TWO 8'h1E
`define IDX_OPTION_ONE 8'h1F

// Register select codes returned by the address decoder.
`define SEL_NONE 3'h0
`define SEL_PORT_A 3'h1
`define SEL_KEY_WAKE_SC 3'h2
`define SEL_KEY_WAKE_IE 3'h3
`define SEL_OPTION_TWO 3'h4
`define SEL_OPTION_ONE 3'h5

// Port A data register.
`define BIT_WAKEUP_LATCH 6

// Key/wake status and control register.
`define BIT_PENDING_FLAG 3
`define BIT_REQUEST_ACK 2
`define BIT_REQUEST_MASK 1

// Key/wake interrupt enable register.
`define BIT_WAKEUP_INT_ENABLE 6

// Option register two.
`define BIT_INT_PIN_PULLUP_DIS 7
`define BIT_INT_PIN_FUNC_EN 6
`define BIT_OSC_RUN_IN_STOP 1
`define BIT_RESET_PIN_FUNC_EN 0

// Option register one.
`define BIT_RATE_SELECT 7
`define BIT_LOW_VOLT_IN_STOP 6
`define BIT_LOW_VOLT_RST_DIS 5
`define BIT_LOW_VOLT_PWR_DIS 4
`define BIT_LOW_VOLT_TRIP 3
`define BIT_SHORT_STOP_REC 2
`define BIT_STOP_ENABLE 1
`define BIT_WATCHDOG_DISABLE 0

// Reset values of single control bits.
`define RST_BIT 1'b0

// Wakeup periods in wakeup clock cycles.
`define WAKE_SHORT_PERIOD 512
`define WAKE_LONG_PERIOD 16384

// Watchdog timeouts and stop recovery delays in quadruple-rate cycles.
`define WDOG_SHORT_CYCLES 18'h0_1FF0
`define WDOG_LONG_CYCLES 18'h3_FFF0
`define RECOVERY_SHORT_CYCLES 13'h0020
`define RECOVERY_LONG_CYCLES 13'h1000

// AHB transfer type bit that marks an active transfer.
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'b0

`endif

//--- rtl/wakeup_period_timer.v
`timescale 1ns/1ps
`include "wakeup_opt_consts.vh"

module wakeup_period_timer #(
  parameter SHORT_PERIOD = `WAKE_SHORT_PERIOD,
  parameter LONG_PERIOD = `WAKE_LONG_PERIOD,
  parameter CNT_W = 14
) (
  // Clock and reset
  input wire clk_in,
  input wire rstn_in,
  // Control
  input wire stop_mode_in,
  input wire use_bus_clock_in,
  input wire short_period_in,
  // Wakeup clock ticks
  input wire rc_tick_in,
  input wire bus2x_tick_in,
  // Result
  output reg overflow_out
);

  localparam integer SHORT_LAST_I = SHORT_PERIOD - 1;
  localparam integer LONG_LAST_I = LONG_PERIOD - 1;
  localparam [CNT_W-1:0] SHORT_LAST = SHORT_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] LONG_LAST = LONG_LAST_I[CNT_W-1:0];

  reg [CNT_W-1:0] count_q;
  wire tick = use_bus_clock_in ? bus2x_tick_in : rc_tick_in;
  wire [CNT_W-1:0] last = short_period_in ? SHORT_LAST : LONG_LAST;

  // Holding the count at zero outside stop mode makes every stop entry start afresh.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_q <= {CNT_W{1'b0}};
      overflow_out <= 1'b0;
    end else if (!stop_mode_in) begin
      count_q <= {CNT_W{1'b0}};
      overflow_out <= 1'b0;
    end else if (tick) begin
      if (count_q >= last) begin
        count_q <= {CNT_W{1'b0}};
        overflow_out <= 1'b1;
      end else begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        overflow_out <= 1'b0;
      end
    end else begin
      overflow_out <= 1'b0;
    end
  end

endmodule // wakeup_period_timer

//--- rtl/wakeup_and_option_registers.v
`timescale 1ns/1ps
`include "wakeup_opt_consts.vh"

module wakeup_and_option_registers #(
  parameter CNT_W = 14
) (
  // Clock and resets
  input wire clk_in,
  input wire rstn_in,
  input wire por_rstn_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // Chip state and events
  input wire stop_mode_in,
  input wire key_event_in,
  input wire lvi_stop_exit_in,
  input wire rc_tick_in,
  input wire bus2x_tick_in,
  // Interrupt to CPU
  output reg key_wake_irq_out,
  // Option controls
  output reg osc_run_in_stop_out,
  output reg [17:0] watchdog_timeout_out,
  output reg [12:0] stop_recovery_out,
  output reg low_volt_monitor_on_out,
  output reg low_volt_reset_enable_out,
  output reg low_volt_trip_5v_out,
  output reg stop_instr_enable_out,
  output reg watchdog_enable_out,
  output reg int_pin_pullup_on_out,
  output reg int_pin_function_out,
  output reg reset_pin_function_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  function [2:0] reg_sel;
    input [31:0] addr;
    begin
      case (addr[9:2])
        `IDX_PORT_A: reg_sel = `SEL_PORT_A;
        `IDX_KEY_WAKE_SC: reg_sel = `SEL_KEY_WAKE_SC;
        `IDX_KEY_WAKE_IE: reg_sel = `SEL_KEY_WAKE_IE;
        `IDX_OPTION_TWO: reg_sel = `SEL_OPTION_TWO;
        `IDX_OPTION_ONE: reg_sel = `SEL_OPTION_ONE;
        default: reg_sel = `SEL_NONE;
      endcase
      if (addr[31:10] != 22'h00_0000 || addr[1:0] != 2'h0) begin
        reg_sel = `SEL_NONE;
      end
    end
  endfunction

  // The state is passed in so that a continuous assignment re-evaluates on every change.
  function wr_hit;
    input pend;
    input [2:0] sel_q;
    input [2:0] code;
    begin
      wr_hit = pend & (sel_q == code);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg wr_pend_q;
  reg [2:0] wr_sel_q;
  reg key_pending_q;
  reg wakeup_latch_q;
  reg request_mask_q;
  reg wakeup_int_enable_q;
  reg opt_two_written_q;
  reg opt_one_written_q;
  reg int_pin_pullup_disable_q;
  reg int_pin_function_enable_q;
  reg osc_run_in_stop_q;
  reg reset_pin_function_enable_q;
  reg rate_select_q;
  reg low_volt_in_stop_q;
  reg low_volt_reset_disable_q;
  reg low_volt_power_disable_q;
  reg low_volt_trip_select_q;
  reg short_stop_recovery_q;
  reg stop_enable_q;
  reg watchdog_disable_q;

  wire addr_phase = hsel_in & hready_in & htrans_in[`HTRANS_ACTIVE_BIT];
  wire [2:0] addr_sel = reg_sel(haddr_in);
  wire wr_sc = wr_hit(wr_pend_q, wr_sel_q, `SEL_KEY_WAKE_SC);
  wire wr_ie = wr_hit(wr_pend_q, wr_sel_q, `SEL_KEY_WAKE_IE);
  wire wr_opt_two = wr_hit(wr_pend_q, wr_sel_q, `SEL_OPTION_TWO) & ~opt_two_written_q;
  wire wr_opt_one = wr_hit(wr_pend_q, wr_sel_q, `SEL_OPTION_ONE) & ~opt_one_written_q;
  wire ack = wr_sc & hwdata_in[`BIT_REQUEST_ACK];
  wire pending_flag = key_pending_q | wakeup_latch_q;
  wire wake_overflow;

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup period timer

  wakeup_period_timer #(
    .SHORT_PERIOD(`WAKE_SHORT_PERIOD),
    .LONG_PERIOD(`WAKE_LONG_PERIOD),
    .CNT_W(CNT_W)
  ) i_wakeup_period_timer (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .stop_mode_in(stop_mode_in),
    .use_bus_clock_in(osc_run_in_stop_q),
    .short_period_in(rate_select_q),
    .rc_tick_in(rc_tick_in),
    .bus2x_tick_in(bus2x_tick_in),
    .overflow_out(wake_overflow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, read data registered in the address phase

  // The master never issues an address in a write's data phase, so a read
  // captured at its own address phase never misses a write still in flight.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_pend_q <= 1'b0;
      wr_sel_q <= `SEL_NONE;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= `HRESP_OKAY;
    end else begin
      wr_pend_q <= addr_phase & hwrite_in;
      wr_sel_q <= addr_sel;
      hreadyout_out <= 1'b1;
      hresp_out <= `HRESP_OKAY;
      if (addr_phase & ~hwrite_in) begin
        hrdata_out <= 32'h0000_0000;
        case (addr_sel)
          `SEL_PORT_A: begin
            hrdata_out[`BIT_WAKEUP_LATCH] <= wakeup_latch_q;
          end
          `SEL_KEY_WAKE_SC: begin
            hrdata_out[`BIT_PENDING_FLAG] <= pending_flag;
            hrdata_out[`BIT_REQUEST_MASK] <= request_mask_q;
          end
          `SEL_KEY_WAKE_IE: begin
            hrdata_out[`BIT_WAKEUP_INT_ENABLE] <= wakeup_int_enable_q;
          end
          `SEL_OPTION_TWO: begin
            hrdata_out[`BIT_INT_PIN_PULLUP_DIS] <= int_pin_pullup_disable_q;
            hrdata_out[`BIT_INT_PIN_FUNC_EN] <= int_pin_function_enable_q;
            hrdata_out[`BIT_OSC_RUN_IN_STOP] <= osc_run_in_stop_q;
            hrdata_out[`BIT_RESET_PIN_FUNC_EN] <= reset_pin_function_enable_q;
          end
          `SEL_OPTION_ONE: begin
            hrdata_out[`BIT_RATE_SELECT] <= rate_select_q;
            hrdata_out[`BIT_LOW_VOLT_IN_STOP] <= low_volt_in_stop_q;
            hrdata_out[`BIT_LOW_VOLT_RST_DIS] <= low_volt_reset_disable_q;
            hrdata_out[`BIT_LOW_VOLT_PWR_DIS] <= low_volt_power_disable_q;
            hrdata_out[`BIT_LOW_VOLT_TRIP] <= low_volt_trip_select_q;
            hrdata_out[`BIT_SHORT_STOP_REC] <= short_stop_recovery_q;
            hrdata_out[`BIT_STOP_ENABLE] <= stop_enable_q;
            hrdata_out[`BIT_WATCHDOG_DISABLE] <= watchdog_disable_q;
          end
          default: begin
            hrdata_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key/wake requests, mask and enable

  // A request arriving in the acknowledge cycle survives: set beats clear.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      key_pending_q <= `RST_BIT;
      wakeup_latch_q <= `RST_BIT;
      request_mask_q <= `RST_BIT;
      wakeup_int_enable_q <= `RST_BIT;
    end else begin
      if (key_event_in) begin
        key_pending_q <= 1'b1;
      end else if (ack) begin
        key_pending_q <= 1'b0;
      end
      if (wake_overflow & wakeup_int_enable_q) begin
        wakeup_latch_q <= 1'b1;
      end else if (ack) begin
        wakeup_latch_q <= 1'b0;
      end
      if (wr_sc) begin
        request_mask_q <= hwdata_in[`BIT_REQUEST_MASK];
      end
      if (wr_ie) begin
        wakeup_int_enable_q <= hwdata_in[`BIT_WAKEUP_INT_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option registers, cleared by any reset except the two bits below that only power-on clears

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      opt_two_written_q <= `RST_BIT;
      opt_one_written_q <= `RST_BIT;
      int_pin_pullup_disable_q <= `RST_BIT;
      int_pin_function_enable_q <= `RST_BIT;
      osc_run_in_stop_q <= `RST_BIT;
      rate_select_q <= `RST_BIT;
      low_volt_in_stop_q <= `RST_BIT;
      low_volt_reset_disable_q <= `RST_BIT;
      low_volt_power_disable_q <= `RST_BIT;
      short_stop_recovery_q <= `RST_BIT;
      stop_enable_q <= `RST_BIT;
      watchdog_disable_q <= `RST_BIT;
    end else begin
      if (wr_opt_two) begin
        opt_two_written_q <= 1'b1;
        int_pin_pullup_disable_q <= hwdata_in[`BIT_INT_PIN_PULLUP_DIS];
        int_pin_function_enable_q <= hwdata_in[`BIT_INT_PIN_FUNC_EN];
        osc_run_in_stop_q <= hwdata_in[`BIT_OSC_RUN_IN_STOP];
      end
      if (wr_opt_one) begin
        opt_one_written_q <= 1'b1;
        rate_select_q <= hwdata_in[`BIT_RATE_SELECT];
        low_volt_in_stop_q <= hwdata_in[`BIT_LOW_VOLT_IN_STOP];
        low_volt_reset_disable_q <= hwdata_in[`BIT_LOW_VOLT_RST_DIS];
        low_volt_power_disable_q <= hwdata_in[`BIT_LOW_VOLT_PWR_DIS];
        short_stop_recovery_q <= hwdata_in[`BIT_SHORT_STOP_REC];
        stop_enable_q <= hwdata_in[`BIT_STOP_ENABLE];
        watchdog_disable_q <= hwdata_in[`BIT_WATCHDOG_DISABLE];
      end
    end
  end

  // These two bits must survive watchdog and pin resets, so only power-on clears them.
  always @(posedge clk_in or negedge por_rstn_in) begin
    if (!por_rstn_in) begin
      reset_pin_function_enable_q <= `RST_BIT;
      low_volt_trip_select_q <= `RST_BIT;
    end else begin
      if (wr_opt_two) begin
        reset_pin_function_enable_q <= hwdata_in[`BIT_RESET_PIN_FUNC_EN];
      end
      if (wr_opt_one) begin
        low_volt_trip_select_q <= hwdata_in[`BIT_LOW_VOLT_TRIP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered controls toward the rest of the chip

  // Interrupt request and wakeup clock control.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      key_wake_irq_out <= 1'b0;
      osc_run_in_stop_out <= 1'b0;
    end else begin
      key_wake_irq_out <= pending_flag & ~request_mask_q;
      osc_run_in_stop_out <= osc_run_in_stop_q;
    end
  end

  // Cycle counts only; the counters that use them live elsewhere on the chip.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      watchdog_timeout_out <= `WDOG_LONG_CYCLES;
      stop_recovery_out <= `RECOVERY_LONG_CYCLES;
    end else begin
      watchdog_timeout_out <= rate_select_q ? `WDOG_SHORT_CYCLES : `WDOG_LONG_CYCLES;
      if (short_stop_recovery_q & ~lvi_stop_exit_in) begin
        stop_recovery_out <= `RECOVERY_SHORT_CYCLES;
      end else begin
        stop_recovery_out <= `RECOVERY_LONG_CYCLES;
      end
    end
  end

  // Low-voltage monitor controls.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_volt_monitor_on_out <= 1'b1;
      low_volt_reset_enable_out <= 1'b1;
      low_volt_trip_5v_out <= 1'b0;
    end else begin
      low_volt_monitor_on_out <= ~low_volt_power_disable_q &
        (~stop_mode_in | low_volt_in_stop_q);
      low_volt_reset_enable_out <= ~low_volt_reset_disable_q;
      low_volt_trip_5v_out <= low_volt_trip_select_q;
    end
  end

  // Instruction, watchdog and pin controls.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_instr_enable_out <= 1'b0;
      watchdog_enable_out <= 1'b1;
      int_pin_pullup_on_out <= 1'b1;
      int_pin_function_out <= 1'b0;
      reset_pin_function_out <= 1'b0;
    end else begin
      stop_instr_enable_out <= stop_enable_q;
      watchdog_enable_out <= ~watchdog_disable_q;
      int_pin_pullup_on_out <= ~int_pin_pullup_disable_q;
      int_pin_function_out <= int_pin_function_enable_q;
      reset_pin_function_out <= reset_pin_function_enable_q;
    end
  end

endmodule // wakeup_and_option_registers

//--- sim/wakeup_opt_checker_sva.sv
`timescale 1ns/1ps
`include "wakeup_opt_consts.vh"

module wakeup_opt_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Events and options
  input wire logic lvi_stop_exit_in,
  input wire logic key_wake_irq_out,
  input wire logic [17:0] watchdog_timeout_out,
  input wire logic [12:0] stop_recovery_out,
  input wire logic watchdog_enable_out
);
  default clocking chk_clk @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////////////////
  wire take = hsel_in & hready_in & htrans_in[1];
  wire wr_sc = take & hwrite_in & (haddr_in == 32'h0000_0068);
  wire wr_o1 = take & hwrite_in & (haddr_in == 32'h0000_007C);
  // Counts option one writes since reset, so a change can be tied to the first one only.
  logic [1:0] o1_cnt_q;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      o1_cnt_q <= 2'h0;
    else if (wr_o1 && o1_cnt_q != 2'h3)
      o1_cnt_q <= o1_cnt_q + 2'h1;
  end

  sequence rd_of(logic [31:0] a);
    take && !hwrite_in && haddr_in == a;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus answer not ready or not okay");
  chk_unmapped_zero: assert property (rd_of(32'h0000_0070) |=> hrdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_status_upper: assert property (rd_of(32'h0000_0068) |=> hrdata_out[31:4] == 28'h000_0000 && !hrdata_out[2])
    else $error("status upper or acknowledge bits read nonzero");
  chk_port_a_bits: assert property (rd_of(32'h0000_0000) |=> hrdata_out[31:7] == 25'h0 && hrdata_out[5:0] == 6'h0)
    else $error("port a shows bits other than the latch");
  // Address edge, data-phase edge, registered output: the write lies three samples back.
  chk_irq_drop_cause: assert property ($fell(key_wake_irq_out) |-> $past(wr_sc, 3))
    else $error("interrupt fell without a status write");
  chk_recovery_lvi: assert property (lvi_stop_exit_in |=> stop_recovery_out == `RECOVERY_LONG_CYCLES)
    else $error("low voltage exit without long recovery");
  chk_recovery_pair: assert property (stop_recovery_out inside {`RECOVERY_SHORT_CYCLES, `RECOVERY_LONG_CYCLES})
    else $error("recovery delay out of set");
  chk_wdog_pair: assert property (watchdog_timeout_out inside {`WDOG_SHORT_CYCLES, `WDOG_LONG_CYCLES})
    else $error("watchdog timeout out of set");
  chk_opt_once: assert property ($changed(watchdog_enable_out) |-> $past(wr_o1, 3) && $past(o1_cnt_q, 3) == 2'h0)
    else $error("option one changed other than by first write");
endmodule // wakeup_opt_checker

//--- sim/wakeup_and_option_registers_bench.sv
`timescale 1ns/1ps
`include "wakeup_opt_consts.vh"

module wakeup_and_option_registers_bench;
  localparam logic [31:0] A_PA = {22'h0, `IDX_PORT_A, 2'h0};
  localparam logic [31:0] A_SC = {22'h0, `IDX_KEY_WAKE_SC, 2'h0};
  localparam logic [31:0] A_IE = {22'h0, `IDX_KEY_WAKE_IE, 2'h0};
  localparam logic [31:0] A_O2 = {22'h0, `IDX_OPTION_TWO, 2'h0};
  localparam logic [31:0] A_O1 = {22'h0, `IDX_OPTION_ONE, 2'h0};
  localparam logic [31:0] A_UN = 32'h0000_0070;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic por_rstn_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0000_0000;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0000_0000;
  logic stop_mode_in = 1'b0;
  logic key_event_in = 1'b0;
  logic lvi_stop_exit_in = 1'b0;
  logic rc_tick_in = 1'b0;
  logic bus2x_tick_in = 1'b0;
  wire [31:0] hrdata_out;
  wire [17:0] watchdog_timeout_out;
  wire [12:0] stop_recovery_out;
  wire hreadyout_out, hresp_out, key_wake_irq_out, osc_run_in_stop_out, low_volt_monitor_on_out;
  wire low_volt_reset_enable_out, low_volt_trip_5v_out, stop_instr_enable_out, watchdog_enable_out;
  wire int_pin_pullup_on_out, int_pin_function_out, reset_pin_function_out;
  logic [31:0] exp_q[$];
  logic dph_rd = 1'b0;
  logic [7:0] d1;
  logic [7:0] d2;
  int seed = 56551;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int per;

  wakeup_and_option_registers i_wakeup_and_option_registers (
    .clk_in, .rstn_in, .por_rstn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2),
    .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .stop_mode_in,
    .key_event_in, .lvi_stop_exit_in, .rc_tick_in, .bus2x_tick_in, .key_wake_irq_out, .osc_run_in_stop_out,
    .watchdog_timeout_out, .stop_recovery_out, .low_volt_monitor_on_out, .low_volt_reset_enable_out,
    .low_volt_trip_5v_out, .stop_instr_enable_out, .watchdog_enable_out, .int_pin_pullup_on_out,
    .int_pin_function_out, .reset_pin_function_out);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  task complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  // Wakeup ticks run only in stop and only on the source the option picks.
  always @(posedge clk_in) begin
    rc_tick_in <= stop_mode_in & !d2[1];
    bus2x_tick_in <= stop_mode_in & d2[1];
  end

  // Read data is taken at the edge that closes the data phase.
  always @(posedge clk_in) begin
    if (dph_rd && hreadyout_out)
      check(hrdata_out, exp_q.pop_front(), "read data");
    if (hsel_in && hreadyout_out && htrans_in[1])
      dph_rd <= !hwrite_in;
    else if (hreadyout_out)
      dph_rd <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    do @(posedge clk_in); while (!hreadyout_out);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    do @(posedge clk_in); while (!hreadyout_out);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask

  task do_reset(input logic pwr_on);
    rstn_in <= 1'b0;
    por_rstn_in <= !pwr_on;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    por_rstn_in <= 1'b1;
  endtask

  initial begin
    d1 = 8'h00;
    d2 = 8'h00;
    for (int pass = 0; pass < 2; pass++) begin
      do_reset(pass == 0);
      rd(A_PA, 32'h0);
      rd(A_SC, 32'h0);
      rd(A_IE, 32'h0);
      rd(A_O1, {28'h0, d1[3], 3'h0});
      rd(A_O2, {31'h0, d2[0]});
      rd(A_UN, 32'h0);
      d1 = pass ? ~d1 : 8'($random(seed));
      d2 = (pass ? ~d2 : 8'($random(seed))) & 8'hC3;
      xfer(1'b1, A_O1, d1);
      xfer(1'b1, A_O2, d2);
      xfer(1'b1, A_O1, ~d1);
      xfer(1'b1, A_O2, ~d2);
      rd(A_O1, {24'h0, d1});
      rd(A_O2, {24'h0, d2});
      check(watchdog_timeout_out, d1[7] ? `WDOG_SHORT_CYCLES : `WDOG_LONG_CYCLES, "timeout");
      check(stop_recovery_out, d1[2] ? `RECOVERY_SHORT_CYCLES : `RECOVERY_LONG_CYCLES, "recovery");
      check({stop_instr_enable_out, watchdog_enable_out, low_volt_reset_enable_out, low_volt_trip_5v_out,
             low_volt_monitor_on_out, int_pin_pullup_on_out, int_pin_function_out, osc_run_in_stop_out,
             reset_pin_function_out}, {d1[1], ~d1[0], ~d1[5], d1[3], ~d1[4], ~d2[7], d2[6], d2[1], d2[0]},
            "options");
      lvi_stop_exit_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      check(stop_recovery_out, `RECOVERY_LONG_CYCLES, "lvi recovery");
      lvi_stop_exit_in <= 1'b0;
      xfer(1'b1, A_IE, 8'h40);
      rd(A_IE, 32'h40);
      key_event_in <= 1'b1;
      @(posedge clk_in);
      key_event_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      check(key_wake_irq_out, 32'h1, "irq");
      rd(A_SC, 32'h08);
      xfer(1'b1, A_SC, 8'h02);
      rd(A_SC, 32'h0A);
      check(key_wake_irq_out, 32'h0, "masked irq");
      xfer(1'b1, A_SC, 8'h06);
      rd(A_SC, 32'h02);
      xfer(1'b1, A_SC, 8'h00);
      // A short stop that is left early must not count toward the next one.
      per = d1[7] ? `WAKE_SHORT_PERIOD : `WAKE_LONG_PERIOD;
      stop_mode_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      check(low_volt_monitor_on_out, !d1[4] & d1[6], "monitor in stop");
      repeat (per / 2) @(posedge clk_in);
      stop_mode_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      stop_mode_in <= 1'b1;
      repeat (per - 24) @(posedge clk_in);
      rd(A_PA, 32'h0);
      repeat (30) @(posedge clk_in);
      rd(A_PA, 32'h40);
      stop_mode_in <= 1'b0;
      xfer(1'b1, A_SC, 8'h04);
      rd(A_PA, 32'h0);
    end
    complete_run();
  end
endmodule // wakeup_and_option_registers_bench

bind wakeup_and_option_registers wakeup_opt_checker i_wakeup_opt_checker (
  .clk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out,
  .hresp_out, .lvi_stop_exit_in, .key_wake_irq_out, .watchdog_timeout_out, .stop_recovery_out,
  .watchdog_enable_out);
